//--- verilog/rdspi_defs.svh
// Constants of the relay driver serial command link: frame layout, replies, timing.
// Assumes inclusion by both link ends and a 250 MHz reference clock.
`ifndef RDSPI_DEFS_SVH
`define RDSPI_DEFS_SVH

// ==========================================================================
// Frame layout
`define RDSPI_FRAME_BITS 16
`define RDSPI_MIN_BITS 5'h10
`define RDSPI_CNT_WRAP 5'h17
`define RDSPI_PFX_WR 2'h2
`define RDSPI_PFX_RD 2'h1
`define RDSPI_PFX_BAD_WR 2'h3
`define RDSPI_PFX_BAD_RD 2'h0
`define RDSPI_TAIL_DIAG 2'h1
`define RDSPI_TAIL_RD 2'h2
`define RDSPI_TER_BIT 10

// ==========================================================================
// Register space and special replies
`define RDSPI_PRIM10_LO 4'hC
`define RDSPI_PRIM10_HI 4'hD
`define RDSPI_PRIM8_MAX 4'h5
`define RDSPI_REG8_NUM 24
`define RDSPI_RST_REPLY 16'hC400
`define RDSPI_SYN_REPLY 16'hC000

// ==========================================================================
// Timing
`define RDSPI_CLK_NS 4
`define RDSPI_LEAD_NS 1000
`define RDSPI_LAG_NS 1000
`define RDSPI_TD_NS 1250
`define RDSPI_HALF_NS 500
`define RDSPI_LEAD_CYC ((`RDSPI_LEAD_NS + `RDSPI_CLK_NS - 1) / `RDSPI_CLK_NS)
`define RDSPI_LAG_CYC ((`RDSPI_LAG_NS + `RDSPI_CLK_NS - 1) / `RDSPI_CLK_NS)
`define RDSPI_TD_CYC ((`RDSPI_TD_NS + `RDSPI_CLK_NS - 1) / `RDSPI_CLK_NS)
`define RDSPI_HALF_CYC ((`RDSPI_HALF_NS + `RDSPI_CLK_NS - 1) / `RDSPI_CLK_NS)

`endif

//--- verilog/rdspi_pkg.sv
// Types shared by the two ends of the relay driver serial command link.
// Assumes the constants header is included by each user.
package rdspi_pkg;
  typedef enum logic [2:0] {
    RDSPI_H_IDLE,
    RDSPI_H_LEAD,
    RDSPI_H_HIGH,
    RDSPI_H_LOW,
    RDSPI_H_LAG,
    RDSPI_H_GAP
  } rdspi_host_st_e;
  typedef logic [15:0] rdspi_frame_t;
endpackage

//--- verilog/rdspi_if.sv
// Wires of the serial command link between host and device.
// Assumes the device end drives the serial output line only while it is selected.
`timescale 1ns/10ps
interface rdspi_if;
  logic sclk;
  logic chip_select_low;
  logic mosi;
  logic miso;
  logic miso_oe;
  wire miso_line;

  // A released line shows the inverse of the last bit, so a late sample cannot pass by luck.
  assign miso_line = miso_oe ? miso : ~miso;

  modport dev (
    input sclk,
    input chip_select_low,
    input mosi,
    output miso,
    output miso_oe
  );
  modport host (
    output sclk,
    output chip_select_low,
    output mosi,
    input miso_line
  );
endinterface

//--- verilog/rdspi_dev.sv
// Device end of the relay driver serial command link: frame decode and reply.
// Assumes link pins come from another domain and are synchronised here.
`timescale 1ns/10ps
`include "rdspi_defs.svh"

// Function
// [R1] Reply to a frame goes out next frame.
// [R2] Bad clock count gives transmission error reply.
// [R3] First reply after any reset is special.
// [R4] Write prefix 11 is a syntax error.
// [R5] Read prefix 00 is a syntax error.
// [R6] Reserved register access is a syntax error.
// [R7] Diagnosis read returns zero plus diagnosis bits.
// [R8] Ten bit write answered with diagnosis.
// [R9] Ten bit read returns prefix, address, content.
// [R10] Eight bit write answered with diagnosis.
// [R11] Eight bit read returns prefix, addresses, content.
// [R12] Host keeps previous command for decoding replies.
// [R13] Input bits captured at falling serial clock.
// [R14] Host keeps select high between frames.
// [R15] Host waits after select before first clock.
// [R16] Host waits after last clock before deselecting.
// [R17] Output idle when deselected, MSB first, rising updates.
// [R18] Frame acted on only at select release.
// [R19] Diagnosis bit ten flags bad previous frame.
// [R20] Erroneous frames write nothing.
module rdspi_dev
  import rdspi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  rdspi_if.dev link,
  input wire logic [14:0] diag_bits_in,
  input wire logic sw_reset_in,
  output logic wr_stb_out,
  output logic [3:0] wr_prim_out,
  output logic [1:0] wr_sec_out,
  output logic [9:0] wr_data_out,
  output logic len_err_out,
  output logic syn_err_out
);

  // ========================================================================
  // Pin synchronisers
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic sk_s1_r, sk_s2_r, sk_d_r;
  logic si_s1_r, si_s2_r;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      sk_s1_r <= 1'b0;
      sk_s2_r <= 1'b0;
      sk_d_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= link.chip_select_low;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      sk_s1_r <= link.sclk;
      sk_s2_r <= sk_s1_r;
      sk_d_r <= sk_s2_r;
      si_s1_r <= link.mosi;
      si_s2_r <= si_s1_r;
    end
  end

  // Serial clock and data share one synchroniser depth, so data seen with a
  // detected edge is the value that stood at that edge.
  logic cs_fall, cs_rise, sk_fall, sk_rise;
  assign cs_fall = cs_d_r & ~cs_s2_r;
  assign cs_rise = ~cs_d_r & cs_s2_r;
  assign sk_fall = sk_d_r & ~sk_s2_r & ~cs_s2_r;
  assign sk_rise = ~sk_d_r & sk_s2_r & ~cs_s2_r;

  // ========================================================================
  // Helpers
  function automatic rdspi_frame_t diag_word(input logic [14:0] d, input logic transfer_fault_flag);
    rdspi_frame_t w;
    w = {1'b0, d};
    w[`RDSPI_TER_BIT] = transfer_fault_flag;
    return w;
  endfunction

  // Returns {valid, ten_bit} for a primary address.
  function automatic logic [1:0] addr_kind(input logic [3:0] prim);
    logic [1:0] k;
    k = 2'h0;
    if (prim == `RDSPI_PRIM10_LO || prim == `RDSPI_PRIM10_HI) begin
      k = 2'h3;
    end else if (prim <= `RDSPI_PRIM8_MAX) begin
      k = 2'h2;
    end
    return k;
  endfunction

  // ========================================================================
  // Register storage
  logic [7:0] reg8 [0:`RDSPI_REG8_NUM-1];
  logic [9:0] reg10 [0:1];
  logic wr_stb_r, wr_stb_nxt;
  logic [3:0] wr_prim_r, wr_prim_nxt;
  logic [1:0] wr_sec_r, wr_sec_nxt;
  logic [9:0] wr_data_r, wr_data_nxt;

  // Writes land one cycle after the frame ends; no read can be decoded sooner.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || sw_reset_in) begin
      for (int i = 0; i < `RDSPI_REG8_NUM; i++) begin
        reg8[i] <= 8'h00;
      end
      reg10[0] <= 10'h000;
      reg10[1] <= 10'h000;
    end else if (wr_stb_r) begin
      if (addr_kind(wr_prim_r) == 2'h3) begin
        reg10[wr_prim_r[0]] <= wr_data_r;
      end else begin
        reg8[{wr_prim_r[2:0], wr_sec_r}] <= wr_data_r[7:0];
      end
    end
  end

  // ========================================================================
  // Frame engine
  rdspi_frame_t sh_r, sh_nxt;
  rdspi_frame_t reply_r, reply_nxt;
  rdspi_frame_t load_w;
  logic so_r, so_nxt;
  logic oe_r, oe_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  logic len_err_r, len_err_nxt;
  logic syn_err_r, syn_err_nxt;
  logic len_ok;
  logic [1:0] kind;

  assign load_w = pend_r ? `RDSPI_RST_REPLY : reply_r;
  assign len_ok = (cnt_r >= `RDSPI_MIN_BITS) && (cnt_r[2:0] == 3'h0);
  assign kind = addr_kind(sh_r[13:10]);

  always_comb begin
    sh_nxt = sh_r;
    reply_nxt = reply_r;
    so_nxt = so_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    len_err_nxt = 1'b0;
    syn_err_nxt = 1'b0;
    wr_stb_nxt = 1'b0;
    wr_prim_nxt = wr_prim_r;
    wr_sec_nxt = wr_sec_r;
    wr_data_nxt = wr_data_r;
    oe_nxt = ~cs_s2_r; // see [R17]
    if (cs_fall) begin
      sh_nxt = load_w; // see [R1] see [R3]
      so_nxt = load_w[15]; // see [R17]
      pend_nxt = 1'b0;
      cnt_nxt = 5'h00;
    end else if (sk_fall) begin
      sh_nxt = {sh_r[14:0], si_s2_r}; // see [R13]
      cnt_nxt = (cnt_r == `RDSPI_CNT_WRAP) ? `RDSPI_MIN_BITS : cnt_r + 5'h01;
    end else if (sk_rise) begin
      so_nxt = sh_r[15]; // see [R17]
    end
    if (cs_rise) begin // see [R18]
      if (!len_ok) begin
        reply_nxt = diag_word(diag_bits_in, 1'b1); // see [R2] see [R19] see [R20]
        len_err_nxt = 1'b1;
      end else if (sh_r[15:14] == `RDSPI_PFX_RD && sh_r[1:0] == `RDSPI_TAIL_RD) begin
        if (kind == 2'h3) begin
          reply_nxt = {`RDSPI_PFX_WR, sh_r[13:10], reg10[sh_r[10]]}; // see [R9]
        end else if (kind == 2'h2) begin
          reply_nxt = {`RDSPI_PFX_WR, sh_r[13:8], reg8[{sh_r[12:10], sh_r[9:8]}]}; // see [R11]
        end else begin
          reply_nxt = `RDSPI_SYN_REPLY; // see [R6]
          syn_err_nxt = 1'b1;
        end
      end else if (sh_r[15] == 1'b0 && sh_r[1:0] == `RDSPI_TAIL_DIAG) begin
        reply_nxt = diag_word(diag_bits_in, 1'b0); // see [R7] see [R19]
      end else if (sh_r[15:14] == `RDSPI_PFX_WR) begin
        if (kind[1]) begin
          reply_nxt = diag_word(diag_bits_in, 1'b0); // see [R8] see [R10]
          wr_stb_nxt = 1'b1;
          wr_prim_nxt = sh_r[13:10];
          wr_sec_nxt = kind[0] ? 2'h0 : sh_r[9:8];
          wr_data_nxt = kind[0] ? sh_r[9:0] : {2'h0, sh_r[7:0]};
        end else begin
          reply_nxt = `RDSPI_SYN_REPLY; // see [R6] see [R20]
          syn_err_nxt = 1'b1;
        end
      end else begin
        reply_nxt = `RDSPI_SYN_REPLY; // see [R4] see [R5] see [R20]
        syn_err_nxt = 1'b1;
      end
    end
    if (sw_reset_in) begin
      pend_nxt = 1'b1; // see [R3]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sh_r <= 16'h0000;
      reply_r <= `RDSPI_RST_REPLY;
      so_r <= 1'b0;
      oe_r <= 1'b0;
      cnt_r <= 5'h00;
      pend_r <= 1'b1;
      len_err_r <= 1'b0;
      syn_err_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_prim_r <= 4'h0;
      wr_sec_r <= 2'h0;
      wr_data_r <= 10'h000;
    end else begin
      sh_r <= sh_nxt;
      reply_r <= reply_nxt;
      so_r <= so_nxt;
      oe_r <= oe_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      len_err_r <= len_err_nxt;
      syn_err_r <= syn_err_nxt;
      wr_stb_r <= wr_stb_nxt;
      wr_prim_r <= wr_prim_nxt;
      wr_sec_r <= wr_sec_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign link.miso = so_r;
  assign link.miso_oe = oe_r;
  assign wr_stb_out = wr_stb_r;
  assign wr_prim_out = wr_prim_r;
  assign wr_sec_out = wr_sec_r;
  assign wr_data_out = wr_data_r;
  assign len_err_out = len_err_r;
  assign syn_err_out = syn_err_r;

endmodule

//--- verilog/rdspi_host.sv
// Host end of the relay driver serial command link: sends 16-bit frames.
// Assumes the device answers on the shared output line; that line is synchronised here.
`timescale 1ns/10ps
`include "rdspi_defs.svh"

module rdspi_host
  import rdspi_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  rdspi_if.host link,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_out,
  output logic [15:0] rsp_cmd_out
);

  // ========================================================================
  // Input synchroniser
  logic mi_s1_r, mi_s2_r;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mi_s1_r <= 1'b0;
      mi_s2_r <= 1'b0;
    end else begin
      mi_s1_r <= link.miso_line;
      mi_s2_r <= mi_s1_r;
    end
  end

  // ========================================================================
  // Frame sequencer
  // The slow-supply figures are used throughout, so they cover normal supply too.
  rdspi_host_st_e st_r, st_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic [3:0] bits_r, bits_nxt;
  rdspi_frame_t tx_r, tx_nxt;
  rdspi_frame_t rx_r, rx_nxt;
  rdspi_frame_t cur_r, cur_nxt;
  rdspi_frame_t last_r, last_nxt;
  rdspi_frame_t rsp_r, rsp_nxt;
  rdspi_frame_t rcmd_r, rcmd_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_r, cs_nxt;
  logic mosi_r, mosi_nxt;
  logic rdy_r, rdy_nxt;
  logic vld_r, vld_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    cur_nxt = cur_r;
    last_nxt = last_r;
    rsp_nxt = rsp_r;
    rcmd_nxt = rcmd_r;
    sclk_nxt = sclk_r;
    cs_nxt = cs_r;
    mosi_nxt = mosi_r;
    vld_nxt = 1'b0;
    case (st_r)
      RDSPI_H_IDLE: begin
        if (cmd_valid_in) begin
          cs_nxt = 1'b0;
          tx_nxt = cmd_in;
          cur_nxt = cmd_in;
          mosi_nxt = cmd_in[15];
          bits_nxt = 4'h0;
          cnt_nxt = 9'(`RDSPI_LEAD_CYC - 1);
          st_nxt = RDSPI_H_LEAD;
        end
      end
      RDSPI_H_LEAD: begin
        if (cnt_r == 9'h000) begin
          sclk_nxt = 1'b1; // see [R15]
          cnt_nxt = 9'(`RDSPI_HALF_CYC - 1);
          st_nxt = RDSPI_H_HIGH;
        end else begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      RDSPI_H_HIGH: begin
        if (cnt_r == 9'h000) begin
          sclk_nxt = 1'b0;
          rx_nxt = {rx_r[14:0], mi_s2_r};
          tx_nxt = {tx_r[14:0], 1'b0};
          bits_nxt = bits_r + 4'h1;
          if (bits_r == 4'hF) begin
            cnt_nxt = 9'(`RDSPI_LAG_CYC - 1);
            st_nxt = RDSPI_H_LAG;
          end else begin
            cnt_nxt = 9'(`RDSPI_HALF_CYC - 1);
            st_nxt = RDSPI_H_LOW;
          end
        end else begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      RDSPI_H_LOW: begin
        if (cnt_r == 9'h000) begin
          sclk_nxt = 1'b1;
          mosi_nxt = tx_r[15]; // Data moves mid-bit, far from the sampling edge.
          cnt_nxt = 9'(`RDSPI_HALF_CYC - 1);
          st_nxt = RDSPI_H_HIGH;
        end else begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      RDSPI_H_LAG: begin
        if (cnt_r == 9'h000) begin
          cs_nxt = 1'b1; // see [R16]
          rsp_nxt = rx_r;
          rcmd_nxt = last_r; // see [R12]
          last_nxt = cur_r;
          vld_nxt = 1'b1;
          cnt_nxt = 9'(`RDSPI_TD_CYC - 1);
          st_nxt = RDSPI_H_GAP;
        end else begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      RDSPI_H_GAP: begin
        if (cnt_r == 9'h000) begin
          st_nxt = RDSPI_H_IDLE; // see [R14]
        end else begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      default: begin
        st_nxt = RDSPI_H_IDLE;
      end
    endcase
    rdy_nxt = (st_nxt == RDSPI_H_IDLE) && !(st_r == RDSPI_H_IDLE && cmd_valid_in);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r <= RDSPI_H_IDLE;
      cnt_r <= 9'h000;
      bits_r <= 4'h0;
      tx_r <= 16'h0000;
      rx_r <= 16'h0000;
      cur_r <= 16'h0000;
      last_r <= 16'h0000;
      rsp_r <= 16'h0000;
      rcmd_r <= 16'h0000;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      mosi_r <= 1'b0;
      rdy_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      cur_r <= cur_nxt;
      last_r <= last_nxt;
      rsp_r <= rsp_nxt;
      rcmd_r <= rcmd_nxt;
      sclk_r <= sclk_nxt;
      cs_r <= cs_nxt;
      mosi_r <= mosi_nxt;
      rdy_r <= rdy_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.chip_select_low = cs_r;
  assign link.mosi = mosi_r;
  assign cmd_ready_out = rdy_r;
  assign rsp_valid_out = vld_r;
  assign rsp_out = rsp_r;
  assign rsp_cmd_out = rcmd_r;

endmodule

//--- bench/rdspi_link_assertions.sv
// Concurrent checks on the serial link wires between the host end and the device end.
// Assumes one reference clock for both ends and reset held high for at least one edge.
`timescale 1ns/10ps
`include "rdspi_defs.svh"

module rdspi_link_assertions (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ==========
  // Cycle counters
  // The gap and low counts saturate, so a long idle spell can never wrap round into a short one.
  logic [8:0] gap_r, gap_nxt, low_r, low_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic sclk_r, sclk_nxt;

  always_comb begin
    gap_nxt = chip_select_low ? gap_r + {8'h00, gap_r != 9'h1FF} : 9'h000;
    low_nxt = (chip_select_low || sclk) ? 9'h000 : low_r + {8'h00, low_r != 9'h1FF};
    bits_nxt = chip_select_low ? 5'h00 : bits_r + {4'h0, sclk_r & !sclk};
    sclk_nxt = sclk;
  end

  // The gap count starts full, since reset counts as a long deselected spell.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gap_r <= 9'h1FF;
      low_r <= 9'h000;
      bits_r <= 5'h00;
      sclk_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      low_r <= low_nxt;
      bits_r <= bits_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  // ==========
  // Assertions
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  chk_oe_off_idle: assert property (
    chip_select_low [*8] |-> !miso_oe) else $error("output driven while deselected");
  chk_oe_on_select: assert property (
    $fell(chip_select_low) |-> ##[1:8] miso_oe) else $error("output not enabled");
  chk_out_on_rise: assert property (
    !chip_select_low && miso_oe && $past(miso_oe) && $changed(miso) |-> sclk)
    else $error("output changed while clock low");
  chk_mosi_held: assert property (
    $fell(sclk) |-> $stable(mosi) [*8]) else $error("data moved near clock fall");
  chk_clk_idle: assert property (
    chip_select_low |-> !sclk) else $error("clock active while deselected");
  chk_frame_bits: assert property (
    $rose(chip_select_low) |-> bits_r == 5'h10) else $error("frame not sixteen clocks");
  chk_select_gap: assert property (
    $fell(chip_select_low) |-> gap_r >= `RDSPI_TD_CYC) else $error("gap too short");
  chk_lead_time: assert property (
    $rose(sclk) && bits_r == 5'h00 |-> low_r >= `RDSPI_LEAD_CYC) else $error("lead too short");
  chk_lag_time: assert property (
    $rose(chip_select_low) |-> low_r >= `RDSPI_LAG_CYC) else $error("lag too short");
endmodule

//--- bench/rdspi_tb.sv
// Bench for the serial command link: host and device joined, plus a second
// device driven bit by bit so that faulty frame lengths can be sent to it.
// Assumes the design files, package and constants header are compiled first.
`timescale 1ns/10ps
`include "rdspi_defs.svh"

module rdspi_tb
  import rdspi_pkg::*;
;
  // ==========
  // Signals and expected replies
  // Bit 10 of the diagnosis input is set so that its replacement shows.
  localparam logic [14:0] DG = 15'h5E5A;
  localparam rdspi_frame_t DG0 = {1'b0, DG[14:11], 1'b0, DG[9:0]};
  localparam rdspi_frame_t DG1 = {1'b0, DG[14:11], 1'b1, DG[9:0]};
  localparam rdspi_frame_t SYN = `RDSPI_SYN_REPLY;
  localparam rdspi_frame_t RST = `RDSPI_RST_REPLY;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic sw_reset = 1'b0;
  rdspi_frame_t cmd = 16'h0000;
  rdspi_frame_t rsp, rsp_cmd, got;
  logic cmd_ready, rsp_valid, wr_stb, syn_err, len_err, wr_stb2;
  logic [3:0] wr_prim;
  logic [1:0] wr_sec;
  logic [9:0] wr_data;
  int bad_count = 0;
  int checked = 0;
  int wr_n = 0;
  int syn_n = 0;
  int len_n = 0;
  int wr2_n = 0;
  // Host frames: write flag, command, reply due in the frame after it.
  logic [32:0] rows [13] = '{
    {1'b1, 16'hB2B5, DG0}, {1'b0, 16'h7002, 16'hB2B5}, {1'b1, 16'h97A7, DG0},
    {1'b0, 16'h5702, 16'h97A7}, {1'b1, 16'h805A, DG0}, {1'b0, 16'h4002, 16'h805A},
    {1'b0, 16'h7FFD, DG0}, {1'b0, 16'hF0F0, SYN}, {1'b0, 16'h0000, SYN},
    {1'b0, 16'h9800, SYN}, {1'b0, 16'h7802, SYN}, {1'b0, 16'h7002, 16'hB2B5},
    {1'b0, 16'h0001, DG0}};
  // Raw frames: clock count, reply due in the first sixteen bits.
  logic [23:0] raws [8] = '{
    {8'h10, RST}, {8'h0C, DG0}, {8'h10, DG1}, {8'h18, DG0},
    {8'h08, 16'h0000}, {8'h10, DG1}, {8'h20, DG0}, {8'h10, DG0}};

  rdspi_if u_if ();
  rdspi_if u_raw_if ();

  rdspi_host u_rdspi_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(u_if.host),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_out(rsp), .rsp_cmd_out(rsp_cmd));
  rdspi_dev u_rdspi_dev (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(u_if.dev),
    .diag_bits_in(DG), .sw_reset_in(sw_reset), .wr_stb_out(wr_stb), .wr_prim_out(wr_prim),
    .wr_sec_out(wr_sec), .wr_data_out(wr_data), .len_err_out(), .syn_err_out(syn_err));
  rdspi_dev u_rdspi_dev_2 (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(u_raw_if.dev),
    .diag_bits_in(DG), .sw_reset_in(1'b0), .wr_stb_out(wr_stb2), .wr_prim_out(),
    .wr_sec_out(), .wr_data_out(), .len_err_out(len_err), .syn_err_out());
  rdspi_link_assertions u_rdspi_link_assertions (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .sclk(u_if.sclk), .chip_select_low(u_if.chip_select_low), .mosi(u_if.mosi),
    .miso(u_if.miso), .miso_oe(u_if.miso_oe));

  always #2 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    wr_n <= wr_n + (wr_stb === 1'b1);
    syn_n <= syn_n + (syn_err === 1'b1);
    len_n <= len_n + (len_err === 1'b1);
    wr2_n <= wr2_n + (wr_stb2 === 1'b1);
  end

  // ==========
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic expire();
    bad_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_of_test();
  endtask

  task automatic xfer(input rdspi_frame_t c);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge ref_clk_in);
      if (++n > 1000) expire();
    end
    @(posedge ref_clk_in);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge ref_clk_in);
    cmd_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge ref_clk_in);
      if (++n > 8000) expire();
    end
    got = rsp;
  endtask

  // Eight-cycle serial clock; the last sixteen bits sent form the command.
  task automatic raw(input logic [7:0] nb, input logic [31:0] pat);
    got = 16'h0000;
    @(posedge ref_clk_in);
    u_raw_if.chip_select_low <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    for (int i = nb - 1; i >= 0; i--) begin
      @(posedge ref_clk_in);
      u_raw_if.sclk <= 1'b1;
      u_raw_if.mosi <= pat[i];
      // The device moves its output a few cycles after the rise, so sample just before the fall.
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      if (nb - 1 - i < 16) got = {got[14:0], u_raw_if.miso_line};
      @(posedge ref_clk_in);
      u_raw_if.sclk <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
    end
    repeat (8) @(posedge ref_clk_in);
    u_raw_if.chip_select_low <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [7:0] nb;
    rdspi_frame_t c, w;
    u_raw_if.sclk = 1'b0;
    u_raw_if.chip_select_low = 1'b1;
    u_raw_if.mosi = 1'b0;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    for (int i = 0; i < 8; i++) begin
      nb = raws[i][23:16];
      raw(nb, (nb[2:0] == 3'h0 && nb >= 8'h10) ? 32'h1 : 32'hB2B5);
      if (nb >= 8'h10) check(got, raws[i][15:0]);
    end
    check(len_n, 2);
    check(wr2_n, 0);
    for (int i = 0; i < 13; i++) begin
      xfer(rows[i][31:16]);
      if (i == 0) begin
        check(got, RST);
      end else begin
        c = rows[i-1][31:16];
        check(got, rows[i-1][15:0]);
        check(rsp_cmd, c);
        if (rows[i-1][32]) begin
          w = (c[13:12] == 2'h3) ? {c[13:10], 2'h0, c[9:0]} : {c[13:10], c[9:8], 2'h0, c[7:0]};
          check({wr_prim, wr_sec, wr_data}, w);
        end
      end
    end
    check(wr_n, 3);
    check(syn_n, 4);
    @(posedge ref_clk_in);
    sw_reset <= 1'b1;
    @(posedge ref_clk_in);
    sw_reset <= 1'b0;
    xfer(16'h7002);
    check(got, RST);
    xfer(16'h0001);
    check(got, 16'hB000);
    end_of_test();
  end
endmodule
